/* dv/clock_sink.sv */
// Model of the CPU and peripherals, counting the clock pulses that reach them.
`default_nettype none
module clock_sink (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic cpuClkEn,
    input wire logic sysClkEn,
    input wire logic subClkEn,
    input wire logic fastClkEn,
    input wire logic slowOscClkEn,
    output logic [15:0] nCpu,
    output logic [15:0] nSys,
    output logic [15:0] nSub,
    output logic [15:0] nFast,
    output logic [15:0] nSlow
);
    // Each consumer counts the enable pulses it sees; a clear starts a new window.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n || clr) begin
            nCpu <= 16'h0000;
            nSys <= 16'h0000;
            nSub <= 16'h0000;
            nFast <= 16'h0000;
            nSlow <= 16'h0000;
        end else begin
            // A pulse is one cycle long, so counting edges counts clock periods.
            nCpu <= nCpu + 16'(cpuClkEn);
            nSys <= nSys + 16'(sysClkEn);
            nSub <= nSub + 16'(subClkEn);
            nFast <= nFast + 16'(fastClkEn);
            nSlow <= nSlow + 16'(slowOscClkEn);
        end
    end
endmodule // clock_sink
`default_nettype wire

/* dv/sysclk_monitor.sv */
// Checker for clock gating and power modes, bound to the controller's top module.
`default_nettype none
module sysclk_monitor
    import sysclk_pkg::*;
#(
    parameter int STABLE_CYCLES = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic haltReq,
    input wire logic wdtEnable,
    input wire logic cpuClkEn,
    input wire logic sysClkEn,
    input wire logic subClkEn,
    input wire logic fastOscRun,
    input wire logic slowOscRun,
    input wire logic hsOscStableFlag,
    input wire sysclk_pkg::mode_t opMode
);
    // Cycles the fast oscillator has run without being reported settled.
    int runCnt;
    int next_runCnt;

    // The count restarts whenever the oscillator stops or the flag is up.
    always_comb begin
        next_runCnt = (fastOscRun && !hsOscStableFlag) ? runCnt + 1 : 0;
    end

    // Register the settle counter.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            runCnt <= 0;
        end else begin
            runCnt <= next_runCnt;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // A halt is only taken while the CPU runs.
    sequence s_halt_taken;
        haltReq && (opMode == MODE_FAST || opMode == MODE_SLOW);
    endsequence
    // A halted mode that was already held one cycle earlier, so registered pulses have drained.
    sequence s_settled(mode_t m);
        opMode == m && $past(opMode) == m;
    endsequence

    a_cpu_run_only: assert property (cpuClkEn |-> (opMode == MODE_FAST || opMode == MODE_SLOW) && sysClkEn)
        else $error("CPU clock pulse outside a run mode");
    a_halt_stops_cpu: assert property (s_halt_taken |=> opMode != MODE_FAST && opMode != MODE_SLOW && !cpuClkEn)
        else $error("Halt did not stop the CPU");
    a_sleep_all_off: assert property (s_settled(MODE_SLEEP) |-> !sysClkEn && !subClkEn && !fastOscRun)
        else $error("Clock running in sleep");
    a_sleep_wdt_osc: assert property (opMode == MODE_SLEEP && $stable(wdtEnable) |-> slowOscRun == wdtEnable)
        else $error("Slow oscillator does not follow watchdog in sleep");
    a_slow_idle_fast_off: assert property (opMode == MODE_IDLE_SLOW_ONLY |-> !fastOscRun && slowOscRun)
        else $error("Wrong oscillators in slow-only idle");
    a_both_idle_on: assert property (opMode == MODE_IDLE_BOTH_OSC |-> fastOscRun && slowOscRun)
        else $error("Oscillator stopped in both-keep idle");
    a_fast_idle_sub_off: assert property (s_settled(MODE_IDLE_FAST_ONLY) |-> !subClkEn && fastOscRun)
        else $error("Wrong clocks in fast-only idle");
    a_flag_follows_osc: assert property (!fastOscRun |=> !hsOscStableFlag)
        else $error("Stable flag up with fast oscillator stopped");
    a_flag_settle_time: assert property ($rose(hsOscStableFlag) |-> runCnt >= STABLE_CYCLES - 2 && runCnt <= STABLE_CYCLES + 2)
        else $error("Stable flag set at the wrong time");
    a_sys_no_runt: assert property (sysClkEn |=> !sysClkEn)
        else $error("Back to back system clock pulses");
endmodule // sysclk_monitor

bind sysclk_select_and_power_modes sysclk_monitor #(
    .STABLE_CYCLES(STABLE_CYCLES)
) u_sysclk_monitor (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .haltReq(haltReq),
    .wdtEnable(wdtEnable),
    .cpuClkEn(cpuClkEn),
    .sysClkEn(sysClkEn),
    .subClkEn(subClkEn),
    .fastOscRun(fastOscRun),
    .slowOscRun(slowOscRun),
    .hsOscStableFlag(hsOscStableFlag),
    .opMode(opMode)
);
`default_nettype wire

/* dv/tb_sysclk_select_and_power_modes.sv */
// Self-checking bench for clock selection, oscillator control and power modes.
`default_nettype none
module tb_sysclk_select_and_power_modes;
    timeunit 1ns;
    timeprecision 100ps;
    import sysclk_pkg::*;
    // Short dividers keep the run brief; every expectation derives from these.
    localparam int FD = 4;
    localparam int SD = 16;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic haltReq = 1'b0;
    logic wakeReq = 1'b0;
    logic wdtEnable = 1'b0;
    logic clr = 1'b0;
    logic [7:0] regRdata;
    logic cpuClkEn, sysClkEn, fastClkEn, subClkEn, slowOscClkEn, fastOscRun, slowOscRun, hsOscStableFlag;
    mode_t opMode;
    logic [15:0] nCpu, nSys, nSub, nFast, nSlow;
    int n_errors = 0;
    int comparisons = 0;

    // Free running 100 MHz clock.
    always #5 core_clk = ~core_clk;

    sysclk_select_and_power_modes #(.FAST_DIV(FD), .SLOW_DIV(SD), .STABLE_CYCLES(8)) u_sysclk_select_and_power_modes (
        .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .haltReq(haltReq), .wakeReq(wakeReq), .wdtEnable(wdtEnable),
        .cpuClkEn(cpuClkEn), .sysClkEn(sysClkEn), .fastClkEn(fastClkEn), .subClkEn(subClkEn),
        .slowOscClkEn(slowOscClkEn), .fastOscRun(fastOscRun), .slowOscRun(slowOscRun),
        .hsOscStableFlag(hsOscStableFlag), .opMode(opMode));
    clock_sink u_clock_sink (
        .core_clk(core_clk), .rst_n(rst_n), .clr(clr), .cpuClkEn(cpuClkEn), .sysClkEn(sysClkEn),
        .subClkEn(subClkEn), .fastClkEn(fastClkEn), .slowOscClkEn(slowOscClkEn),
        .nCpu(nCpu), .nSys(nSys), .nSub(nSub), .nFast(nFast), .nSlow(nSlow));

    // Prints the verdict and ends the run.
    task automatic complete_run();
        $display("Comparisons %0d, errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Compares one value; four-state equality so unknowns never match.
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-cycle register write.
    task automatic regWr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask

    // One-cycle read; the data stand only in the following cycle.
    task automatic regRd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask

    // Bounded wait for the fast oscillator to report settled.
    task automatic waitFlag();
        for (int i = 0; i < 400 && hsOscStableFlag !== 1'b1; i++) @(posedge core_clk);
        if (hsOscStableFlag !== 1'b1) begin
            n_errors++;
            $display("[ERR] stable flag expected 1 seen 0");
            complete_run();
        end
    endtask

    // Counts pulses over exactly n clock edges.
    task automatic measure(input int n);
        @(posedge core_clk);
        clr <= 1'b1;
        @(posedge core_clk);
        clr <= 1'b0;
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // One-cycle halt or wake request; the mode answers one cycle later.
    task automatic pulse(input bit halt);
        @(posedge core_clk);
        haltReq <= halt;
        wakeReq <= !halt;
        @(posedge core_clk);
        haltReq <= 1'b0;
        wakeReq <= 1'b0;
        #1;
    endtask

    // Reset values, read-only flag, unimplemented bits and an unmapped offset.
    task automatic t_regs();
        logic [7:0] d;
        regRd(REG_SYSCLK_CTRL, d); check("ctrl reset", 16'(d), 16'h0000);
        regRd(REG_OSC_CTRL, d); check("osc reset", 16'(d), 16'h0001);
        regRd(4'h5, d); check("unmapped", 16'(d), 16'h0000);
        waitFlag();
        regWr(REG_OSC_CTRL, 8'h01);
        regRd(REG_OSC_CTRL, d); check("osc settled", 16'(d), 16'h0003);
        regWr(REG_OSC_CTRL, 8'h00);
        regWr(REG_OSC_CTRL, 8'h01);
        #1 check("flag cleared on enable", 16'(hsOscStableFlag), 16'h0000);
        waitFlag();
        regWr(REG_SYSCLK_CTRL, 8'h1C);
        regRd(REG_SYSCLK_CTRL, d); check("ctrl unused bits", 16'(d), 16'h0000);
    endtask

    // Every selector code: divide ratio of the fast clock, then the sub clock.
    task automatic t_ratio();
        int e;
        for (int s = 0; s < 8; s++) begin
            regWr(REG_SYSCLK_CTRL, {3'(s), 5'h00});
            repeat (300) @(posedge core_clk);
            measure(512);
            e = (s == 7) ? 512 / SD : 512 / (FD << s);
            check("sys pulses", nSys, 16'(e));
            check("cpu pulses", nCpu, 16'(e));
            check("fast pulses", nFast, 16'(512 / FD));
        end
    endtask

    // Running from the sub clock, the fast oscillator follows its enable bit.
    task automatic t_hs_enable();
        regWr(REG_OSC_CTRL, 8'h00);
        repeat (5) @(posedge core_clk);
        check("fast osc off", 16'(fastOscRun), 16'h0000);
        measure(64);
        check("fast stopped", nFast, 16'h0000);
        check("sys on sub", nSys, 16'(64 / SD));
        regWr(REG_OSC_CTRL, 8'h01);
        #1 check("flag clear", 16'(hsOscStableFlag), 16'h0000);
        waitFlag();
        check("fast osc on", 16'(fastOscRun), 16'h0001);
    endtask

    // Each idle-keep pair with a fast and the sub selector, halt refusal and wake.
    task automatic t_modes();
        mode_t m;
        logic [2:0] sel;
        for (int i = 0; i < 8; i++) begin
            sel = i[2] ? 3'h7 : 3'h0;
            @(posedge core_clk);
            wdtEnable <= i[2];
            regWr(REG_SYSCLK_CTRL, {sel, 3'h0, 2'(i)});
            repeat (300) @(posedge core_clk);
            waitFlag();
            m = (i[1:0] == 0) ? MODE_SLEEP : (i[1:0] == 1) ? MODE_IDLE_SLOW_ONLY :
                (i[1:0] == 2) ? MODE_IDLE_FAST_ONLY : MODE_IDLE_BOTH_OSC;
            pulse(1'b1);
            check("halt mode", 16'(opMode), 16'(m));
            pulse(1'b1);
            check("halt refused", 16'(opMode), 16'(m));
            measure(64);
            check("cpu halted", nCpu, 16'h0000);
            check("sys in idle", 16'(nSys != 0), 16'(m == MODE_IDLE_BOTH_OSC ||
                (m == MODE_IDLE_SLOW_ONLY && sel == 3'h7) || (m == MODE_IDLE_FAST_ONLY && sel != 3'h7)));
            check("sub in idle", 16'(nSub != 0), 16'(m != MODE_SLEEP && m != MODE_IDLE_FAST_ONLY));
            check("fast in idle", 16'(nFast != 0), 16'(m == MODE_IDLE_FAST_ONLY || m == MODE_IDLE_BOTH_OSC));
            check("slow osc", 16'(nSlow != 0), 16'(m != MODE_SLEEP || i[2]));
            pulse(1'b0);
            check("wake mode", 16'(opMode), 16'((sel == 3'h7) ? MODE_SLOW : MODE_FAST));
        end
        pulse(1'b0);
        check("wake refused", 16'(opMode), 16'(MODE_SLOW));
    endtask

    // Reset for 20 cycles, then every scenario in turn.
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        t_regs();
        t_ratio();
        t_hs_enable();
        t_modes();
        complete_run();
    end
endmodule // tb_sysclk_select_and_power_modes
`default_nettype wire

/* pkg/sysclk_pkg.sv */
// Shared constants, register map and mode type for the system clock and power mode controller.
`default_nettype none
package sysclk_pkg;
    // Core clock rate, used to turn times into cycle counts.
    localparam int CORE_CLK_MHZ = 100;
    // Period of the fast RC oscillator in ns (8 MHz), and its length in core cycles (rounded down).
    localparam int FAST_OSC_PERIOD_NS = 125;
    localparam int FAST_OSC_CYCLES = (FAST_OSC_PERIOD_NS * CORE_CLK_MHZ) / 1000;
    // Period of the slow RC oscillator in ns (32 kHz), and its length in core cycles (rounded down).
    localparam int SLOW_OSC_PERIOD_NS = 31250;
    localparam int SLOW_OSC_CYCLES = (SLOW_OSC_PERIOD_NS * CORE_CLK_MHZ) / 1000;
    // Least settling time of the fast oscillator in ns, and in core cycles (rounded up).
    localparam int HS_STABLE_NS = 2000;
    localparam int HS_STABLE_CYCLES = (HS_STABLE_NS * CORE_CLK_MHZ + 999) / 1000;
    // Register bus widths.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // Register offsets.
    localparam logic [3:0] REG_SYSCLK_CTRL = 4'h0;
    localparam logic [3:0] REG_OSC_CTRL = 4'h1;
    // Field positions.
    localparam int SEL_LSB = 5;
    localparam int SEL_W = 3;
    localparam int HS_KEEP_BIT = 1;
    localparam int LS_KEEP_BIT = 0;
    localparam int STABLE_BIT = 1;
    localparam int HS_EN_BIT = 0;
    // Reset values.
    localparam logic [2:0] SEL_RST = 3'h0;
    localparam logic HS_KEEP_RST = 1'b0;
    localparam logic LS_KEEP_RST = 1'b0;
    localparam logic HS_EN_RST = 1'b1;
    // Selector code of the sub clock.
    localparam logic [2:0] SEL_SUB = 3'h7;
    // Width of the fast prescaler, enough for the largest ratio of 64.
    localparam int PRESC_W = 6;
    // Operating modes.
    typedef enum logic [2:0] {
        MODE_FAST,
        MODE_SLOW,
        MODE_SLEEP,
        MODE_IDLE_SLOW_ONLY,
        MODE_IDLE_BOTH_OSC,
        MODE_IDLE_FAST_ONLY
    } mode_t;
endpackage
`default_nettype wire

/* rtl/sysclk_select_and_power_modes.sv */
// System clock selection, fast prescaler, oscillator gating and power mode control.
//
// What this block does
// - Three-bit selector picks fast or sub clock.
// - Codes 000-110 divide fast by 1..64; 111 sub.
// - Fast clock comes from the fast RC oscillator.
// - Sub clock comes from the slow RC oscillator.
// - FAST mode runs CPU and system on divided fast clock.
// - SLOW mode runs CPU from sub clock.
// - In SLOW, fast oscillator follows its enable bit unless a move to fast is pending.
// - Six modes: two run, four stop CPU.
// - Halt with both keeps low enters SLEEP.
// - SLEEP keeps slow oscillator only with watchdog.
// - Slow-keep-only idle keeps sub, system if 111.
// - Both-keep idle keeps fast, sub and system.
// - Fast-keep-only idle keeps fast, system if fast.
// - Enabling fast oscillator clears then sets stable flag.
//
// Every clock towards the CPU and peripherals is a one-cycle enable pulse on core_clk.
`default_nettype none
module sysclk_select_and_power_modes
    import sysclk_pkg::*;
#(
    parameter int FAST_DIV = sysclk_pkg::FAST_OSC_CYCLES,
    parameter int SLOW_DIV = sysclk_pkg::SLOW_OSC_CYCLES,
    parameter int STABLE_CYCLES = sysclk_pkg::HS_STABLE_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [sysclk_pkg::ADDR_W-1:0] regAddr,
    input wire logic [sysclk_pkg::DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [sysclk_pkg::DATA_W-1:0] regRdata,
    input wire logic haltReq,
    input wire logic wakeReq,
    input wire logic wdtEnable,
    output logic cpuClkEn,
    output logic sysClkEn,
    output logic fastClkEn,
    output logic subClkEn,
    output logic slowOscClkEn,
    output logic fastOscRun,
    output logic slowOscRun,
    output logic hsOscStableFlag,
    output sysclk_pkg::mode_t opMode
);
    import sysclk_pkg::*;

    localparam int SW = (STABLE_CYCLES > 1) ? $clog2(STABLE_CYCLES + 1) : 1;
    localparam logic [SW-1:0] STABLE_LAST = SW'(STABLE_CYCLES - 1);
    localparam logic [PRESC_W-1:0] PRESC_ALL = {PRESC_W{1'b1}};

    // Software-visible control fields.
    logic [2:0] sysClkSel; // Requested selector as written by software.
    logic hsIdleKeep; // Keep the fast oscillator while halted.
    logic lsIdleKeep; // Keep the slow oscillator while halted.
    logic hsOscEnable; // Fast oscillator enable in SLOW mode.
    logic [2:0] next_sysClkSel;
    logic next_hsIdleKeep;
    logic next_lsIdleKeep;
    logic next_hsOscEnable;
    logic [DATA_W-1:0] next_regRdata;

    // Clock tree state.
    logic [2:0] activeSel; // Selector that the system clock really follows.
    logic [PRESC_W-1:0] prescCount; // Fast prescaler, counts fast ticks.
    logic [SW-1:0] stableCount; // Settling counter of the fast oscillator.
    mode_t next_opMode;
    logic [2:0] next_activeSel;
    logic [PRESC_W-1:0] next_prescCount;
    logic [SW-1:0] next_stableCount;
    logic next_hsOscStableFlag;
    logic next_cpuClkEn;
    logic next_sysClkEn;
    logic next_fastClkEn;
    logic next_subClkEn;
    logic next_slowOscClkEn;
    logic next_fastOscRun;
    logic next_slowOscRun;

    // Oscillator ticks and helper terms.
    logic fastTick; // One pulse per fast oscillator period.
    logic slowTick; // One pulse per slow oscillator period.
    logic hsEnRise; // Software turns the fast oscillator enable from off to on.
    logic [PRESC_W:0] shiftOne;
    logic [PRESC_W-1:0] divMask;
    logic divTick; // Fast clock divided by the active ratio.
    logic fastReady; // Fast oscillator running and settled.
    logic sysOn; // Mode keeps the system clock running.

    // Fast RC oscillator model; it only oscillates while fastOscRun is high.
    tick_divider #(
        .DIV(FAST_DIV)
    ) u_fast_osc (
        .clk(core_clk),
        .rst_n(rst_n),
        .run(fastOscRun),
        .tick(fastTick)
    );

    // Slow RC oscillator model; it only oscillates while slowOscRun is high.
    tick_divider #(
        .DIV(SLOW_DIV)
    ) u_slow_osc (
        .clk(core_clk),
        .rst_n(rst_n),
        .run(slowOscRun),
        .tick(slowTick)
    );

    // Register writes and reads; reads answer one cycle later, unmapped offsets read zero.
    always_comb begin
        next_sysClkSel = sysClkSel;
        next_hsIdleKeep = hsIdleKeep;
        next_lsIdleKeep = lsIdleKeep;
        next_hsOscEnable = hsOscEnable;
        next_regRdata = '0;
        if (regWrite) begin
            if (regAddr == REG_SYSCLK_CTRL) begin
                // Bits 4 to 2 are not implemented and drop on write.
                next_sysClkSel = regWdata[SEL_LSB +: SEL_W];
                next_hsIdleKeep = regWdata[HS_KEEP_BIT];
                next_lsIdleKeep = regWdata[LS_KEEP_BIT];
            end else if (regAddr == REG_OSC_CTRL) begin
                // The stable flag is read only; only the enable is written.
                next_hsOscEnable = regWdata[HS_EN_BIT];
            end
        end
        if (regRead) begin
            if (regAddr == REG_SYSCLK_CTRL) begin
                next_regRdata[SEL_LSB +: SEL_W] = sysClkSel;
                next_regRdata[HS_KEEP_BIT] = hsIdleKeep;
                next_regRdata[LS_KEEP_BIT] = lsIdleKeep;
            end else if (regAddr == REG_OSC_CTRL) begin
                next_regRdata[STABLE_BIT] = hsOscStableFlag;
                next_regRdata[HS_EN_BIT] = hsOscEnable;
            end
        end
    end

    // Register the software fields and the read data.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sysClkSel <= SEL_RST;
            hsIdleKeep <= HS_KEEP_RST;
            lsIdleKeep <= LS_KEEP_RST;
            hsOscEnable <= HS_EN_RST;
            regRdata <= '0;
        end else begin
            sysClkSel <= next_sysClkSel;
            hsIdleKeep <= next_hsIdleKeep;
            lsIdleKeep <= next_lsIdleKeep;
            hsOscEnable <= next_hsOscEnable;
            regRdata <= next_regRdata;
        end
    end

    // Helper terms shared by the clock tree logic.
    always_comb begin
        hsEnRise = regWrite && (regAddr == REG_OSC_CTRL) && regWdata[HS_EN_BIT] && !hsOscEnable;
        fastReady = fastOscRun && hsOscStableFlag;
        // A ratio of 2^n fires when the low n prescaler bits are all ones.
        shiftOne = (PRESC_W + 1)'(1) << activeSel;
        divMask = shiftOne[PRESC_W-1:0] - PRESC_W'(1);
        divTick = fastTick && fastReady && ((prescCount & divMask) == divMask);
    end

    // Mode sequencing, clock selection, oscillator gating and the stable flag.
    always_comb begin
        next_opMode = opMode;
        next_activeSel = activeSel;
        next_prescCount = prescCount;
        next_stableCount = stableCount;
        next_hsOscStableFlag = hsOscStableFlag;
        sysOn = 1'b0;

        // Halt leaves the run modes according to the two keep bits; wake returns to the run mode of the selector.
        case (opMode)
            MODE_FAST, MODE_SLOW: begin
                if (haltReq) begin
                    if (!hsIdleKeep && !lsIdleKeep) begin
                        next_opMode = MODE_SLEEP;
                    end else if (!hsIdleKeep && lsIdleKeep) begin
                        next_opMode = MODE_IDLE_SLOW_ONLY;
                    end else if (hsIdleKeep && lsIdleKeep) begin
                        next_opMode = MODE_IDLE_BOTH_OSC;
                    end else begin
                        next_opMode = MODE_IDLE_FAST_ONLY;
                    end
                end else begin
                    next_opMode = (activeSel == SEL_SUB) ? MODE_SLOW : MODE_FAST;
                end
            end
            default: begin
                // All four halted modes keep the CPU stopped until a wake request.
                if (wakeReq) begin
                    next_opMode = (activeSel == SEL_SUB) ? MODE_SLOW : MODE_FAST;
                end
            end
        endcase

        // The system clock changes source or ratio only at a boundary where every candidate period ends,
        // so no shortened pulse appears. A move to the fast clock also waits for it to settle.
        if (sysClkSel != activeSel) begin
            if (sysClkSel == SEL_SUB) begin
                if (slowTick) begin
                    next_activeSel = sysClkSel;
                end
            end else if (fastReady && fastTick && (prescCount == PRESC_ALL)) begin
                next_activeSel = sysClkSel;
            end
        end

        // The prescaler steps on each fast tick so all ratios stay in phase.
        if (!fastOscRun) begin
            next_prescCount = '0;
        end else if (fastTick) begin
            next_prescCount = prescCount + PRESC_W'(1);
        end

        // Settling: cleared while stopped or on a fresh enable, then set once the count elapses.
        if (!fastOscRun || hsEnRise) begin
            next_stableCount = '0;
            next_hsOscStableFlag = 1'b0;
        end else if (!hsOscStableFlag) begin
            if (stableCount == STABLE_LAST) begin
                next_hsOscStableFlag = 1'b1;
            end else begin
                next_stableCount = stableCount + SW'(1);
            end
        end

        // Oscillator run controls per mode, taken from the mode being entered.
        case (next_opMode)
            MODE_FAST: begin
                next_fastOscRun = 1'b1;
                next_slowOscRun = 1'b1;
                sysOn = 1'b1;
            end
            MODE_SLOW: begin
                // The fast oscillator follows its enable, or runs while a move back to it is pending.
                next_fastOscRun = hsOscEnable || (sysClkSel != SEL_SUB);
                next_slowOscRun = 1'b1;
                sysOn = 1'b1;
            end
            MODE_IDLE_SLOW_ONLY: begin
                next_fastOscRun = 1'b0;
                next_slowOscRun = 1'b1;
                sysOn = (activeSel == SEL_SUB);
            end
            MODE_IDLE_BOTH_OSC: begin
                next_fastOscRun = 1'b1;
                next_slowOscRun = 1'b1;
                sysOn = 1'b1;
            end
            MODE_IDLE_FAST_ONLY: begin
                next_fastOscRun = 1'b1;
                // The slow oscillator still runs for the watchdog, but the sub clock is gated off.
                next_slowOscRun = 1'b1;
                sysOn = (activeSel != SEL_SUB);
            end
            default: begin
                next_fastOscRun = 1'b0;
                next_slowOscRun = wdtEnable;
                sysOn = 1'b0;
            end
        endcase

        // Clock enables towards the CPU and peripherals.
        next_sysClkEn = sysOn && ((activeSel == SEL_SUB) ? slowTick : divTick);
        next_cpuClkEn = ((next_opMode == MODE_FAST) || (next_opMode == MODE_SLOW)) && next_sysClkEn;
        next_fastClkEn = fastTick && fastReady;
        next_subClkEn = slowTick && (opMode != MODE_SLEEP) && (opMode != MODE_IDLE_FAST_ONLY);
        next_slowOscClkEn = slowTick;
    end

    // Register the clock tree state and every output except regRdata, which the register block drives.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            opMode <= MODE_FAST;
            activeSel <= SEL_RST;
            prescCount <= '0;
            stableCount <= '0;
            hsOscStableFlag <= 1'b0;
            cpuClkEn <= 1'b0;
            sysClkEn <= 1'b0;
            fastClkEn <= 1'b0;
            subClkEn <= 1'b0;
            slowOscClkEn <= 1'b0;
            fastOscRun <= 1'b0;
            slowOscRun <= 1'b0;
        end else begin
            opMode <= next_opMode;
            activeSel <= next_activeSel;
            prescCount <= next_prescCount;
            stableCount <= next_stableCount;
            hsOscStableFlag <= next_hsOscStableFlag;
            cpuClkEn <= next_cpuClkEn;
            sysClkEn <= next_sysClkEn;
            fastClkEn <= next_fastClkEn;
            subClkEn <= next_subClkEn;
            slowOscClkEn <= next_slowOscClkEn;
            fastOscRun <= next_fastOscRun;
            slowOscRun <= next_slowOscRun;
        end
    end
endmodule // sysclk_select_and_power_modes
`default_nettype wire

/* rtl/tick_divider.sv */
// Free divider that models an RC oscillator as a one-cycle tick on the core clock.
`default_nettype none
module tick_divider #(
    parameter int DIV = 12
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    output logic tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] count; // Cycles since the last tick.
    logic [CW-1:0] next_count;
    logic next_tick;

    // Count while running; a stopped oscillator restarts from zero so its first tick is a full period.
    always_comb begin
        next_count = count;
        next_tick = 1'b0;
        if (!run) begin
            next_count = '0;
        end else if (count == LAST) begin
            next_count = '0;
            next_tick = 1'b1;
        end else begin
            next_count = count + CW'(1);
        end
    end

    // Register the count and the tick.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule // tick_divider
`default_nettype wire
